// ---- src/oag_pkg.sv ----
package oag_pkg;

    localparam int WORD_W = 16;
    localparam int NUM_DEFAULT_WORKING_REGISTER = 16;
    localparam int WSEL_W = 4;
    localparam int FADDR_W = 13;
    localparam int NEAR_BYTES = 8192;
    localparam int LIT5_W = 5;
    localparam int LIT10_W = 10;
    localparam int MODV_W = 4;
    localparam logic [WSEL_W-1:0] DEFAULT_DEFAULT_WORKING_REGISTER = 4'h0;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

    // operand addressing mode
    typedef enum logic [2:0] {
        OAG_MODE_FILE = 3'b000,
        OAG_MODE_RDIR = 3'b001,
        OAG_MODE_RIND = 3'b010,
        OAG_MODE_POST = 3'b011,
        OAG_MODE_PRE = 3'b100,
        OAG_MODE_RIDX = 3'b101,
        OAG_MODE_LOFF = 3'b110,
        OAG_MODE_LIT = 3'b111
    } oag_mode_t;

    // instruction class
    typedef enum logic [1:0] {
        OAG_CLS_FILE = 2'b00,
        OAG_CLS_XFER = 2'b01,
        OAG_CLS_ALU3 = 2'b10,
        OAG_CLS_MACC = 2'b11
    } oag_cls_t;

    // result destination
    typedef enum logic [1:0] {
        OAG_DST_FILE = 2'b00,
        OAG_DST_DEFAULT_WORKING_REGISTER = 2'b01,
        OAG_DST_MEM = 2'b10,
        OAG_DST_PAIR = 2'b11
    } oag_dst_t;

    // decoded instruction fields from the decoder
    typedef struct packed {
        oag_cls_t cls;
        oag_mode_t mode;
        oag_dst_t dst;
        logic isProduct;
        logic litLong;
        logic [FADDR_W-1:0] fileAddr;
        logic [WSEL_W-1:0] ptrSel;
        logic [WSEL_W-1:0] baseSel;
        logic [WSEL_W-1:0] dstSel;
        logic [LIT10_W-1:0] literal;
        logic [MODV_W-1:0] modStep;
    } oag_instr_t;

    // operand result toward memory bus and datapath
    typedef struct packed {
        logic memRead;
        logic [WORD_W-1:0] effAddr;
        logic [WORD_W-1:0] operand1;
        logic [WORD_W-1:0] operand2;
        logic useLiteral;
        oag_dst_t dst;
        logic [WSEL_W-1:0] dstSel;
        logic [WORD_W-1:0] dstAddr;
    } oag_op_t;

endpackage

// ---- src/oag_operand_address_gen.sv ----
`timescale 1ns/100ps
// Function
// - direct file instructions use 13-bit address into first 8192 data bytes.
// - file instructions take working operand from first working register.
// - file results go to file or default register; product may use pair.
// - data transfer instruction may address the whole data space.
// - three-operand first source is always a working register, direct mode.
// - second source is a working register, memory via working register, or 5-bit literal.
// - three-operand result goes to working register or data memory.
// - modes: direct, indirect, post-, pre-modified, 5 or 10-bit literal.
// - each instruction accepts only its permitted subset of modes.
// - file direct mode takes address from instruction field.
// - register direct uses register contents, no memory access.
// - register indirect uses pointer contents unchanged as address.
// - post-modify uses pointer as address, then steps it.
// - pre-modify steps pointer by signed constant, then uses it.
// - register indexed address is pointer plus base register.
// - literal offset address is pointer plus instruction literal.
// - multiply-accumulate class has its own modes, refused here.
module oag_operand_address_gen (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // decoded instruction
    input wire logic instrValid,
    input oag_pkg::oag_instr_t instr,
    // register file write from datapath
    input wire logic wrEn,
    input wire logic [oag_pkg::WSEL_W-1:0] wrSel,
    input wire logic [oag_pkg::WORD_W-1:0] wrData,
    // operand output
    output logic opValid,
    output oag_pkg::oag_op_t op,
    output logic modeIllegal
);
    import oag_pkg::*;

    logic [WORD_W-1:0] default_working_register_q [NUM_DEFAULT_WORKING_REGISTER];
    oag_op_t op_q;
    oag_op_t op_d;
    logic opValid_q;
    logic illegal_q;

    wire logic [WORD_W-1:0] ptrVal = default_working_register_q[instr.ptrSel];
    wire logic [WORD_W-1:0] baseVal = default_working_register_q[instr.baseSel];
    wire logic [WORD_W-1:0] defVal = default_working_register_q[DEFAULT_DEFAULT_WORKING_REGISTER];
    wire logic [WORD_W-1:0] stepExt =
        {{(WORD_W-MODV_W){instr.modStep[MODV_W-1]}}, instr.modStep};
    wire logic [WORD_W-1:0] ptrMod = WORD_W'(ptrVal + stepExt);
    wire logic [WORD_W-1:0] lit5 =
        {{(WORD_W-LIT5_W){1'b0}}, instr.literal[LIT5_W-1:0]};
    wire logic [WORD_W-1:0] lit10 =
        {{(WORD_W-LIT10_W){1'b0}}, instr.literal};
    wire logic [WORD_W-1:0] litVal = instr.litLong ? lit10 : lit5;
    wire logic [WORD_W-1:0] nearAddr =
        {{(WORD_W-FADDR_W){1'b0}}, instr.fileAddr};

    // permitted mode subsets per class
    wire logic fileOk = (instr.mode == OAG_MODE_FILE);
    wire logic xferOk = (instr.mode != OAG_MODE_LIT) || instr.litLong;
    wire logic alu3Ok = (instr.mode == OAG_MODE_RDIR) ||
        (instr.mode == OAG_MODE_RIND) || (instr.mode == OAG_MODE_POST) ||
        (instr.mode == OAG_MODE_PRE) ||
        ((instr.mode == OAG_MODE_LIT) && !instr.litLong);
    wire logic dstOk = (instr.cls == OAG_CLS_FILE) ?
        (instr.dst == OAG_DST_FILE || instr.dst == OAG_DST_DEFAULT_WORKING_REGISTER ||
         (instr.dst == OAG_DST_PAIR && instr.isProduct)) :
        (instr.dst == OAG_DST_DEFAULT_WORKING_REGISTER || instr.dst == OAG_DST_MEM);
    wire logic modeOk =
        (instr.cls == OAG_CLS_FILE) ? (fileOk && dstOk) :
        (instr.cls == OAG_CLS_XFER) ? dstOk && xferOk :
        (instr.cls == OAG_CLS_ALU3) ? (alu3Ok && dstOk) :
        1'b0;
    wire logic accept = instrValid && modeOk;
    wire logic ptrWrite = accept &&
        (instr.mode == OAG_MODE_POST || instr.mode == OAG_MODE_PRE);

    // effective address per mode
    always_comb begin
        op_d = '0;
        op_d.dst = instr.dst;
        op_d.dstSel = instr.dstSel;
        op_d.dstAddr = nearAddr;
        op_d.operand1 = (instr.cls == OAG_CLS_ALU3) ? baseVal : defVal;
        unique case (instr.mode)
            OAG_MODE_FILE: begin
                op_d.effAddr = nearAddr;
                op_d.memRead = 1'b1;
            end
            OAG_MODE_RDIR: begin
                op_d.operand2 = ptrVal;
            end
            OAG_MODE_RIND: begin
                op_d.effAddr = ptrVal;
                op_d.memRead = 1'b1;
            end
            OAG_MODE_POST: begin
                op_d.effAddr = ptrVal;
                op_d.memRead = 1'b1;
            end
            OAG_MODE_PRE: begin
                op_d.effAddr = ptrMod;
                op_d.memRead = 1'b1;
            end
            OAG_MODE_RIDX: begin
                op_d.effAddr = WORD_W'(ptrVal + baseVal);
                op_d.memRead = 1'b1;
            end
            OAG_MODE_LOFF: begin
                op_d.effAddr = WORD_W'(ptrVal + litVal);
                op_d.memRead = 1'b1;
            end
            OAG_MODE_LIT: begin
                op_d.operand2 = litVal;
                op_d.useLiteral = 1'b1;
            end
        endcase
    end

    // working registers with pointer write-back
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DEFAULT_WORKING_REGISTER; gi++) begin : g_default_working_register
            always_ff @(posedge ref_clk) begin
                if (!nrst) begin
                    default_working_register_q[gi] <= WORD_ZERO;
                end else if (ptrWrite && instr.ptrSel == WSEL_W'(gi)) begin
                    default_working_register_q[gi] <= ptrMod;
                end else if (wrEn && wrSel == WSEL_W'(gi)) begin
                    default_working_register_q[gi] <= wrData;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            op_q <= '0;
            opValid_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            op_q <= accept ? op_d : op_q;
            opValid_q <= accept;
            illegal_q <= instrValid && !modeOk;
        end
    end

    assign op = op_q;
    assign opValid = opValid_q;
    assign modeIllegal = illegal_q;

endmodule // oag_operand_address_gen

// ---- dv/oag_dec_model.sv ----
`timescale 1ns/100ps
// decoder side: packs a legal destination and fields from a raw word
module oag_dec_model (
    input oag_pkg::oag_cls_t cls,
    input oag_pkg::oag_mode_t mode,
    input wire logic [15:0] raw,
    output oag_pkg::oag_instr_t instr
);
    import oag_pkg::*;
    oag_dst_t dst;
    assign dst = (cls == OAG_CLS_FILE) ? OAG_DST_FILE : OAG_DST_DEFAULT_WORKING_REGISTER;
    assign instr = '{cls, mode, dst, 1'b0, 1'b0, raw[12:0], raw[3:0],
        raw[7:4], raw[11:8], {5'h00, raw[4:0]}, raw[15:12]};
endmodule // oag_dec_model

// ---- dv/oag_monitor.sv ----
`timescale 1ns/100ps
module oag_monitor (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic instrValid,
    input oag_pkg::oag_instr_t instr,
    input wire logic opValid,
    input oag_pkg::oag_op_t op,
    input wire logic modeIllegal
);
    import oag_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire logic iFil = instrValid && instr.cls == OAG_CLS_FILE;
    wire logic iAlu = instrValid && instr.cls == OAG_CLS_ALU3;
    a_pulse_excl: assert property (!(opValid && modeIllegal))
        else $error("accept and refuse together");
    a_macc_refused: assert property (
        instrValid && instr.cls == OAG_CLS_MACC |=> modeIllegal)
        else $error("multiply class not refused");
    a_file_only: assert property (
        iFil && instr.mode != OAG_MODE_FILE |=> modeIllegal)
        else $error("file class took other mode");
    a_file_addr: assert property (iFil && instr.mode == OAG_MODE_FILE |=>
        modeIllegal || (opValid && op.effAddr == {3'h0, $past(instr.fileAddr)}))
        else $error("file address wrong");
    a_rdir_nomem: assert property (
        instrValid && instr.mode == OAG_MODE_RDIR |=> !(opValid && op.memRead))
        else $error("register direct read memory");
    a_lit_flag: assert property (
        instrValid && instr.mode == OAG_MODE_LIT |=> !opValid || op.useLiteral)
        else $error("literal not flagged");
    a_alu_ridx: assert property (
        iAlu && instr.mode == OAG_MODE_RIDX |=> modeIllegal && !opValid)
        else $error("indexed mode taken by alu");
    a_op_holds: assert property (!opValid |-> $stable(op))
        else $error("operand changed without accept");
    cover property (opValid && op.memRead);
    cover property (opValid && op.useLiteral);
    cover property (modeIllegal);
endmodule // oag_monitor
bind oag_operand_address_gen oag_monitor u_mon (.ref_clk, .nrst, .instrValid,
    .instr, .opValid, .op, .modeIllegal);

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    import oag_pkg::*;
    logic ref_clk, nrst, instrValid, wrEn, opValid, modeIllegal, ok;
    logic [3:0] wrSel;
    logic [15:0] wrData, raw, ptr, st;
    logic [15:0] r [16];
    oag_cls_t cls;
    oag_mode_t mode;
    oag_instr_t instr;
    oag_op_t op;
    int n_fail, checked;
    oag_dec_model dec (.cls, .mode, .raw, .instr);
    oag_operand_address_gen dut (.ref_clk, .nrst, .instrValid, .instr,
        .wrEn, .wrSel, .wrData, .opValid, .op, .modeIllegal);
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        stop_test;
    end
    initial begin
        {nrst, instrValid, wrEn, wrSel, wrData, raw} = '0;
        cls = OAG_CLS_FILE;
        mode = OAG_MODE_FILE;
        void'($urandom(32'hb258e3dc));
        repeat (5) @(posedge ref_clk);
        #1 chk({15'h0, opValid}, 16'h0000);
        @(posedge ref_clk) nrst <= 1;
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            r[i] = 16'($urandom);
            wrEn <= 1;
            wrSel <= i[3:0];
            wrData <= r[i];
        end
        @(posedge ref_clk) wrEn <= 0;
        $display("test register load done");
        repeat (600) begin
            @(posedge ref_clk);
            cls <= oag_cls_t'($urandom_range(3));
            mode <= oag_mode_t'($urandom_range(7));
            raw <= 16'($urandom);
            instrValid <= 1;
            @(posedge ref_clk) instrValid <= 0;
            #1 ptr = r[raw[3:0]];
            st = ptr + {{12{raw[15]}}, raw[15:12]};
            ok = cls == OAG_CLS_FILE ? mode == OAG_MODE_FILE :
                cls == OAG_CLS_XFER ? mode != OAG_MODE_LIT :
                cls == OAG_CLS_ALU3 && mode inside {OAG_MODE_RDIR,
                OAG_MODE_RIND, OAG_MODE_POST, OAG_MODE_PRE, OAG_MODE_LIT};
            chk({15'h0, opValid}, {15'h0, ok});
            chk({15'h0, modeIllegal}, {15'h0, !ok});
            if (ok) begin
                chk(op.operand1, cls == OAG_CLS_ALU3 ? r[raw[7:4]] : r[0]);
                chk({14'h0, op.dst}, {14'h0, instr.dst});
                chk({12'h0, op.dstSel}, {12'h0, raw[11:8]});
                chk({15'h0, op.memRead}, {15'h0, !(mode inside {OAG_MODE_RDIR,
                    OAG_MODE_LIT})});
                chk({15'h0, op.useLiteral}, {15'h0, mode == OAG_MODE_LIT});
                case (mode)
                    OAG_MODE_FILE: chk(op.effAddr, {3'h0, raw[12:0]});
                    OAG_MODE_RIND, OAG_MODE_POST: chk(op.effAddr, ptr);
                    OAG_MODE_PRE: chk(op.effAddr, st);
                    OAG_MODE_RIDX: chk(op.effAddr, ptr + r[raw[7:4]]);
                    OAG_MODE_LOFF: chk(op.effAddr, ptr + {11'h0, raw[4:0]});
                    OAG_MODE_RDIR: chk(op.operand2, ptr);
                    default: chk(op.operand2, {11'h0, raw[4:0]});
                endcase
                if (mode inside {OAG_MODE_POST, OAG_MODE_PRE}) r[raw[3:0]] = st;
            end
        end
        $display("test random operands done");
        stop_test;
    end
endmodule // testbench
